// File: pll_ctrl_pkg.sv
// Package: register map, field positions and types for the link PLL control bank
// Functional notes
// RULE_01: Bit 0 at 0x500 written one forces a link PLL reset from the register map.
// RULE_02: Lock output follows state machine unless bit 6 set, then equals bit 7.
// RULE_03: Enable control bit 5 makes the logic ignore the PLL lock input.
// RULE_04: Writing one to enable control bit 3 clears the sticky lock-loss flag.
// RULE_05: Pulse on bit 1 starts VCO calibration; pulse lasts at least one clock.
// RULE_06: Bit 0 powers up PLL, starts regulator, calibrates, then signals lock.
// RULE_07: Status bit 4 sets on any lock loss and stays until software clears it.
// RULE_08: Status bits 3 and 0 read high while locked, low otherwise.
// RULE_09: Status bit 2 rises on calibration start edge, falls when last step ends.
// RULE_10: Status bit 1 high after regulator stays above threshold for enough checks.
// RULE_11: Calibration-enable bits 4 and 3 enable transmit and receive clock outputs.
// RULE_12: Calibration-enable bit 1 routes output clocks to the serializer only.
// RULE_13: Calibration-enable bit 0 enables PLL octave calibration.
// RULE_14: Divider bit 7 selects reference output divided by forty or one hundred twenty.
// RULE_15: Divider bit 6 selects feedback factor times six or times eight.
// RULE_16: Output divider bits 5:4 divide by one or two by low bit; reset 2.
// RULE_17: Input divider bits 2:0 divide by 1,2,4,8, or 16 for codes four up.
// RULE_18: Reserved bits read zero and ignore writes.
package pll_ctrl_pkg;
  // ----------------------------------------------------------------
  // Register indices and byte address width
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_RESET = 12'h500;
  localparam logic [11:0] IDX_ENABLE = 12'h501;
  localparam logic [11:0] IDX_STATUS = 12'h502;
  localparam logic [11:0] IDX_ENCAL = 12'h506;
  localparam logic [11:0] IDX_DIVIDER = 12'h507;
  localparam int ADDR_W = 14;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_LINK_RESET = 0;
  localparam int BIT_OVR_VALUE = 7;
  localparam int BIT_OVR_EN = 6;
  localparam int BIT_LOCK_IGNORE = 5;
  localparam int BIT_LOSS_CLEAR = 3;
  localparam int BIT_CAL_TRIGGER = 1;
  localparam int BIT_POWER_UP = 0;
  localparam int BIT_ST_LOSS = 4;
  localparam int BIT_ST_RF_LOCK = 3;
  localparam int BIT_ST_CAL = 2;
  localparam int BIT_ST_REG = 1;
  localparam int BIT_ST_LOCK = 0;
  localparam int BIT_TX_DIST = 4;
  localparam int BIT_RX_DIST = 3;
  localparam int BIT_SER_ONLY = 1;
  localparam int BIT_OCTAVE = 0;
  localparam int BIT_REF_SEL = 7;
  localparam int BIT_FB_SEL = 6;
  localparam int BIT_ODIV_LO = 4;
  // ----------------------------------------------------------------
  // Writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_RESET = 8'h01;
  localparam logic [7:0] MASK_ENABLE = 8'hEB;
  localparam logic [7:0] MASK_ENCAL = 8'h1B;
  localparam logic [7:0] MASK_DIVIDER = 8'hF7;
  localparam logic [7:0] RST_RESET = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_ENCAL = 8'h00;
  localparam logic [7:0] RST_DIVIDER = 8'h22;
  // ----------------------------------------------------------------
  // Divider ratios and timing
  // ----------------------------------------------------------------
  localparam logic [6:0] REF_DIV_LOW = 7'h28;
  localparam logic [6:0] REF_DIV_HIGH = 7'h78;
  localparam logic [3:0] FB_MULT_LOW = 4'h6;
  localparam logic [3:0] FB_MULT_HIGH = 4'h8;
  localparam int CLK_MHZ = 10;
  localparam int REG_CHECK_US = 2;
  localparam int REG_CHECK_CYC = REG_CHECK_US * CLK_MHZ;
  localparam int REG_CHECK_COUNT = 4;
  localparam int CAL_STEP_CYC = 16;
  localparam int CAL_STEPS = 4;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_REGULATOR = 5'b00010,
    ST_CALIBRATE = 5'b00100,
    ST_LOCKED = 5'b01000,
    ST_UNLOCKED = 5'b10000
  } pll_state_e;

  typedef struct packed {
    logic tx_dist;
    logic rx_dist;
    logic ser_only;
    logic octave_cal;
    logic [6:0] ref_out_div;
    logic [3:0] fb_mult;
    logic [1:0] out_div;
    logic [4:0] in_div;
  } pll_cfg_s;

  // Input divider code to ratio
  function automatic logic [4:0] in_div_ratio(input logic [2:0] code);
    if (code[2]) begin
      in_div_ratio = 5'h10;
    end else begin
      in_div_ratio = 5'(5'h01 << code[1:0]);
    end
  endfunction
endpackage

// File: pll_step_timer.sv
// Counter that pulses when a run of steps of fixed length completes
`timescale 1ns/1ps
module pll_step_timer #(
  parameter int STEP_CYC = 16,
  parameter int STEPS = 4
) (
  input wire logic clk_in, // Reference clock
  input wire logic reset_in, // Synchronous reset
  input wire logic run_in, // Count while high
  input wire logic ok_in, // Step passes only while high
  output logic done_out // Pulse when last step completes
);
  localparam int TOTAL = STEP_CYC * STEPS;
  logic [15:0] cnt_q;
  wire logic hit = (cnt_q == 16'(TOTAL - 1));
  always_ff @(posedge clk_in) begin
    if (reset_in || !run_in || !ok_in || hit) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= run_in && ok_in && hit;
    end
  end
endmodule // pll_step_timer

// File: pll_ctrl_regs.sv
// Link PLL control and status register bank on AXI4-Lite
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module pll_ctrl_regs
  import pll_ctrl_pkg::*;
(
  input wire logic clk_in, // 10 MHz reference clock
  input wire logic reset_in, // Synchronous active-high reset
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic pll_lock_in, // Analog PLL lock pin
  input wire logic reg_above_in, // Regulator above threshold pin
  output logic link_reset_out, // Link PLL reset, active high
  output logic pll_power_out, // PLL power enable
  output logic cal_busy_out, // VCO calibration running
  output logic locked_out, // Lock indication
  output pll_cfg_s cfg_out // Clock distribution and divider settings
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] lock_sync_q;
  logic [1:0] reg_sync_q;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lock_sync_q <= 2'h0;
      reg_sync_q <= 2'h0;
    end else begin
      lock_sync_q <= {lock_sync_q[0], pll_lock_in};
      reg_sync_q <= {reg_sync_q[0], reg_above_in};
    end
  end
  wire logic lock_pin = lock_sync_q[1];
  wire logic reg_pin = reg_sync_q[1];

  // ----------------------------------------------------------------
  // Bus slave: address and data may arrive in either order
  // ----------------------------------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  wire logic [11:0] wr_idx = awaddr_q[ADDR_W-1:2];
  wire logic [11:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
  wire logic wr_lane0 = wr_fire && wstrb_q[0];
  wire logic [7:0] wbyte = wdata_q[7:0];
  wire logic ar_take = s_axi_arvalid && s_axi_arready;

  function automatic logic idx_known(input logic [11:0] idx);
    idx_known = (idx == IDX_RESET) || (idx == IDX_ENABLE) || (idx == IDX_STATUS) ||
                (idx == IDX_ENCAL) || (idx == IDX_DIVIDER);
  endfunction

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held_q && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !w_held_q && !w_take && !s_axi_bvalid;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= idx_known(wr_idx) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= idx_known(rd_idx) ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers; reserved bits never store [RULE_18]
  // ----------------------------------------------------------------
  logic [7:0] rst_reg_q;
  logic [7:0] en_reg_q;
  logic [7:0] encal_reg_q;
  logic [7:0] div_reg_q;
  logic loss_clear_q;
  wire logic wr_rst = wr_lane0 && (wr_idx == IDX_RESET);
  wire logic wr_en = wr_lane0 && (wr_idx == IDX_ENABLE);
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rst_reg_q <= RST_RESET;
      en_reg_q <= RST_ENABLE;
      encal_reg_q <= RST_ENCAL;
      div_reg_q <= RST_DIVIDER;
      loss_clear_q <= 1'b0;
    end else begin
      if (wr_rst) begin
        rst_reg_q <= wbyte & MASK_RESET; // [RULE_18]
      end
      if (wr_en) begin
        en_reg_q <= wbyte & MASK_ENABLE; // [RULE_18]
      end
      if (wr_lane0 && wr_idx == IDX_ENCAL) begin
        encal_reg_q <= wbyte & MASK_ENCAL; // [RULE_18]
      end
      if (wr_lane0 && wr_idx == IDX_DIVIDER) begin
        div_reg_q <= wbyte & MASK_DIVIDER; // [RULE_18]
      end
      loss_clear_q <= wr_en && wbyte[BIT_LOSS_CLEAR]; // [RULE_04]
    end
  end

  // ----------------------------------------------------------------
  // Power-up, regulator and calibration sequence
  // ----------------------------------------------------------------
  pll_state_e state_q;
  pll_state_e state_d;
  logic [7:0] reg_wait_q;
  logic [2:0] reg_checks_q;
  logic reg_ok_q;
  logic cal_trig_q;
  logic cal_prog_q;
  logic loss_q;
  logic cal_done;
  wire logic link_reset = rst_reg_q[BIT_LINK_RESET]; // [RULE_01]
  wire logic power_req = en_reg_q[BIT_POWER_UP];
  wire logic lock_eff = lock_pin || en_reg_q[BIT_LOCK_IGNORE]; // [RULE_03]
  wire logic cal_edge = en_reg_q[BIT_CAL_TRIGGER] && !cal_trig_q; // [RULE_05]
  wire logic check_tick = (reg_wait_q == 8'(REG_CHECK_CYC - 1));
  wire logic sm_lock = (state_q == ST_LOCKED);
  wire logic lock_ind = en_reg_q[BIT_OVR_EN] ? en_reg_q[BIT_OVR_VALUE] : sm_lock; // [RULE_02]
  wire logic lost = (state_q == ST_LOCKED) && !lock_eff;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: if (power_req) state_d = ST_REGULATOR; // [RULE_06]
      ST_REGULATOR: if (reg_ok_q) state_d = ST_CALIBRATE; // [RULE_06]
      ST_CALIBRATE: if (cal_done) state_d = lock_eff ? ST_LOCKED : ST_UNLOCKED;
      ST_LOCKED: if (!lock_eff) state_d = ST_UNLOCKED;
      ST_UNLOCKED: if (lock_eff) state_d = ST_LOCKED;
      default: state_d = ST_OFF;
    endcase
    if (cal_edge && state_q != ST_OFF && state_q != ST_REGULATOR) begin
      state_d = ST_CALIBRATE; // [RULE_05]
    end
    if (!power_req || link_reset) begin
      state_d = ST_OFF; // [RULE_01]
    end
  end

  pll_step_timer #(
    .STEP_CYC(CAL_STEP_CYC),
    .STEPS(CAL_STEPS)
  ) u_cal_timer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .run_in(state_q == ST_CALIBRATE && !cal_edge),
    .ok_in(reg_ok_q),
    .done_out(cal_done)
  );

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= ST_OFF;
      reg_wait_q <= 8'h00;
      reg_checks_q <= 3'h0;
      reg_ok_q <= 1'b0;
      cal_trig_q <= 1'b0;
      cal_prog_q <= 1'b0;
      loss_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cal_trig_q <= en_reg_q[BIT_CAL_TRIGGER];
      if (!power_req || link_reset || check_tick) begin
        reg_wait_q <= 8'h00;
      end else begin
        reg_wait_q <= reg_wait_q + 8'h01;
      end
      if (!power_req || link_reset || (check_tick && !reg_pin)) begin
        reg_checks_q <= 3'h0;
        reg_ok_q <= 1'b0;
      end else if (check_tick && !reg_ok_q) begin
        reg_checks_q <= reg_checks_q + 3'h1;
        reg_ok_q <= (reg_checks_q == 3'(REG_CHECK_COUNT - 1)); // [RULE_10]
      end
      if (state_d == ST_CALIBRATE && state_q != ST_CALIBRATE) begin
        cal_prog_q <= 1'b1; // [RULE_09]
      end else if (cal_edge && state_q == ST_CALIBRATE) begin
        cal_prog_q <= 1'b1; // [RULE_09]
      end else if (cal_done || state_d == ST_OFF) begin
        cal_prog_q <= 1'b0; // [RULE_09]
      end
      if (lost) begin
        loss_q <= 1'b1; // [RULE_07]
      end else if (loss_clear_q) begin
        loss_q <= 1'b0; // [RULE_04]
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, read data and outputs
  // ----------------------------------------------------------------
  wire logic [7:0] status = {3'h0, loss_q, sm_lock, cal_prog_q, reg_ok_q, sm_lock}; // [RULE_08]
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      IDX_RESET: rd_byte = rst_reg_q;
      IDX_ENABLE: rd_byte = en_reg_q;
      IDX_STATUS: rd_byte = status;
      IDX_ENCAL: rd_byte = encal_reg_q;
      IDX_DIVIDER: rd_byte = div_reg_q;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_axi_rdata <= 32'h00000000;
      link_reset_out <= 1'b0;
      pll_power_out <= 1'b0;
      cal_busy_out <= 1'b0;
      locked_out <= 1'b0;
      cfg_out <= '0;
    end else begin
      if (ar_take) begin
        s_axi_rdata <= {24'h000000, rd_byte};
      end
      link_reset_out <= link_reset; // [RULE_01]
      pll_power_out <= (state_d != ST_OFF); // [RULE_06]
      cal_busy_out <= cal_prog_q;
      locked_out <= lock_ind; // [RULE_02]
      cfg_out.tx_dist <= encal_reg_q[BIT_TX_DIST]; // [RULE_11]
      cfg_out.rx_dist <= encal_reg_q[BIT_RX_DIST]; // [RULE_11]
      cfg_out.ser_only <= encal_reg_q[BIT_SER_ONLY]; // [RULE_12]
      cfg_out.octave_cal <= encal_reg_q[BIT_OCTAVE]; // [RULE_13]
      cfg_out.ref_out_div <= div_reg_q[BIT_REF_SEL] ? REF_DIV_HIGH : REF_DIV_LOW; // [RULE_14]
      cfg_out.fb_mult <= div_reg_q[BIT_FB_SEL] ? FB_MULT_HIGH : FB_MULT_LOW; // [RULE_15]
      cfg_out.out_div <= div_reg_q[BIT_ODIV_LO] ? 2'h2 : 2'h1; // [RULE_16]
      cfg_out.in_div <= in_div_ratio(div_reg_q[2:0]); // [RULE_17]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_cal_pulse;
    $rose(en_reg_q[BIT_CAL_TRIGGER]) && (state_q == ST_LOCKED) && power_req && !link_reset;
  endsequence

  AST_RESET_OUT: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_01]
    link_reset |=> link_reset_out) else $error("link reset not driven");
  AST_LOCK_OVR: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_02]
    en_reg_q[BIT_OVR_EN] |=> locked_out == $past(en_reg_q[BIT_OVR_VALUE]))
    else $error("lock override ignored");
  AST_LOCK_IGN: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_03]
    (state_q == ST_LOCKED) && en_reg_q[BIT_LOCK_IGNORE] && power_req && !link_reset
    && !cal_edge |=> state_q == ST_LOCKED) else $error("ignored lock input dropped lock");
  AST_LOSS_CLR: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_04]
    loss_clear_q && !lost |=> !loss_q) else $error("loss flag not cleared");
  AST_CAL_START: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_05]
    s_cal_pulse |=> (state_q == ST_CALIBRATE) && cal_prog_q) else $error("calibration not started");
  AST_POWER: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_06]
    (state_q == ST_OFF) && power_req && !link_reset |=> state_q == ST_REGULATOR)
    else $error("power up not begun");
  AST_LOSS_STICKY: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_07]
    lost |=> loss_q) else $error("loss of lock not recorded");
  AST_STATUS_LOCK: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_08]
    status[BIT_ST_LOCK] == (state_q == ST_LOCKED) && status[BIT_ST_RF_LOCK] == status[BIT_ST_LOCK])
    else $error("lock status mismatch");
  AST_CAL_END: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_09]
    cal_done && !cal_edge && power_req && !link_reset |=> !cal_prog_q)
    else $error("calibration flag stuck");
  AST_REG_OK: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_10]
    $rose(reg_ok_q) |-> $past(reg_pin)) else $error("regulator ready without level");
  AST_DIV_IN: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_17]
    div_reg_q[2] |=> cfg_out.in_div == 5'h10) else $error("input divider wrong");
  AST_REG_DROP: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_10]
    check_tick && !reg_pin |=> !reg_ok_q) else $error("regulator ready kept after low check");
  AST_TX_DIST: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_11]
    1'b1 |=> cfg_out.tx_dist == $past(encal_reg_q[BIT_TX_DIST]))
    else $error("transmit clock enable wrong");
  AST_RX_DIST: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_11]
    1'b1 |=> cfg_out.rx_dist == $past(encal_reg_q[BIT_RX_DIST]))
    else $error("receive clock enable wrong");
  AST_SER_ONLY: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_12]
    1'b1 |=> cfg_out.ser_only == $past(encal_reg_q[BIT_SER_ONLY]))
    else $error("serializer only routing wrong");
  AST_OCTAVE: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_13]
    1'b1 |=> cfg_out.octave_cal == $past(encal_reg_q[BIT_OCTAVE]))
    else $error("octave calibration enable wrong");
  AST_REF_DIV: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_14]
    1'b1 |=> cfg_out.ref_out_div == ($past(div_reg_q[BIT_REF_SEL]) ? 7'h78 : 7'h28))
    else $error("reference output divider wrong");
  AST_FB_MULT: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_15]
    1'b1 |=> cfg_out.fb_mult == ($past(div_reg_q[BIT_FB_SEL]) ? 4'h8 : 4'h6))
    else $error("feedback multiplier wrong");
  AST_OUT_DIV: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_16]
    1'b1 |=> cfg_out.out_div == ($past(div_reg_q[BIT_ODIV_LO]) ? 2'h2 : 2'h1))
    else $error("output divider wrong");
  AST_RESERVED: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE_18]
    (en_reg_q & 8'h14) == 8'h00 && encal_reg_q[7:5] == 3'h0 && !encal_reg_q[2]
    && !div_reg_q[3] && rst_reg_q[7:1] == 7'h00) else $error("reserved bit stored");
endmodule // pll_ctrl_regs

// File: tb_serializer_pll_control_regs.sv
// Self-checking testbench for the link PLL control register bank
`timescale 1ns/1ps
module tb_serializer_pll_control_regs;
  import pll_ctrl_pkg::*;
  localparam logic [7:0] ENC_BITS [4] = '{8'h10, 8'h08, 8'h02, 8'h01};
  logic clk_in, reset_in, pll_lock_in, reg_above_in;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs, bs;
  logic link_reset_out, pll_power_out, cal_busy_out, locked_out;
  pll_cfg_s cfg_out;
  logic [2:0] c;
  logic [7:0] d;
  int n_errors, checked, i;

  pll_ctrl_regs i_pll_ctrl_regs (.clk_in(clk_in), .reset_in(reset_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pll_lock_in(pll_lock_in), .reg_above_in(reg_above_in), .link_reset_out(link_reset_out),
    .pll_power_out(pll_power_out), .cal_busy_out(cal_busy_out), .locked_out(locked_out),
    .cfg_out(cfg_out));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    check_word(name, {31'h0, exp}, {31'h0, got});
  endtask

  // Extra edges at the end let registered outputs settle before any check
  task automatic wr(input logic [11:0] idx, input logic [7:0] dat);
    awaddr <= ADDR_W'({idx, 2'b00});
    wdata <= {24'h0, dat};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check_bit("write answer", 1'b1, bvalid);
    bs = bresp;
    bready <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  task automatic rd_reg(input logic [11:0] idx);
    araddr <= ADDR_W'({idx, 2'b00});
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    check_bit("read answer", 1'b1, rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] idx, input logic [7:0] exp);
    rd_reg(idx);
    check_word(name, {24'h0, exp}, rd);
    check_word("read resp", 32'h0, {30'h0, rs});
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and sequence
  // ------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    complete_run();
  end

  initial begin
    n_errors = 0;
    checked = 0;
    reset_in = 1'b1;
    pll_lock_in = 1'b1;
    reg_above_in = 1'b1;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'h1;
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rd_chk("reset reg", IDX_RESET, 8'h00);
    rd_chk("enable reg", IDX_ENABLE, 8'h00);
    rd_chk("status reg", IDX_STATUS, 8'h00);
    rd_chk("encal reg", IDX_ENCAL, 8'h00);
    rd_chk("divider reg", IDX_DIVIDER, 8'h22);
    check_word("in div", 32'h4, {27'h0, cfg_out.in_div});
    check_word("out div", 32'h1, {30'h0, cfg_out.out_div});
    wr(IDX_RESET, 8'hFF);
    check_bit("link reset", 1'b1, link_reset_out);
    rd_chk("reset reg", IDX_RESET, 8'h01);
    wr(IDX_RESET, 8'h00);
    check_bit("link reset", 1'b0, link_reset_out);
    wr(IDX_ENABLE, 8'h14);
    rd_chk("enable reg", IDX_ENABLE, 8'h00);
    wr(IDX_STATUS, 8'hFF);
    rd_chk("status reg", IDX_STATUS, 8'h00);
    wr(IDX_ENCAL, 8'hFF);
    rd_chk("encal reg", IDX_ENCAL, 8'h1B);
    for (i = 0; i < 4; i++) begin
      wr(IDX_ENCAL, ENC_BITS[i]);
      check_word("clk enables", 32'h8 >> i, {28'h0, cfg_out.tx_dist, cfg_out.rx_dist,
        cfg_out.ser_only, cfg_out.octave_cal});
    end
    wr(12'h503, 8'hFF);
    check_word("unmapped bresp", 32'h2, {30'h0, bs});
    rd_reg(12'h503);
    check_word("unmapped rresp", 32'h2, {30'h0, rs});
    check_word("unmapped data", 32'h0, rd);
    for (i = 0; i < 8; i++) begin
      c = i[2:0];
      d = {c[0], c[1], c[1:0], 1'b0, c};
      wr(IDX_DIVIDER, d);
      rd_chk("divider reg", IDX_DIVIDER, d);
      check_word("ref div", c[0] ? 32'h78 : 32'h28, {25'h0, cfg_out.ref_out_div});
      check_word("fb mult", c[1] ? 32'h8 : 32'h6, {28'h0, cfg_out.fb_mult});
      check_word("out div", c[0] ? 32'h2 : 32'h1, {30'h0, cfg_out.out_div});
      check_word("in div", c[2] ? 32'h10 : 32'h1 << c[1:0], {27'h0, cfg_out.in_div});
    end
    wr(IDX_ENABLE, 8'h01);
    check_bit("power", 1'b1, pll_power_out);
    rd_chk("status early", IDX_STATUS, 8'h00);
    for (i = 0; i < 600 && locked_out !== 1'b1; i++) @(posedge clk_in);
    check_bit("locked", 1'b1, locked_out);
    rd_chk("status locked", IDX_STATUS, 8'h0B);
    wr(IDX_ENABLE, 8'h41);
    check_bit("lock forced low", 1'b0, locked_out);
    wr(IDX_ENABLE, 8'h01);
    pll_lock_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    check_bit("locked", 1'b0, locked_out);
    rd_chk("status loss", IDX_STATUS, 8'h12);
    wr(IDX_ENABLE, 8'hC1);
    check_bit("lock forced high", 1'b1, locked_out);
    wr(IDX_ENABLE, 8'h01);
    pll_lock_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rd_reg(IDX_STATUS);
    check_bit("loss sticky", 1'b1, rd[4]);
    wr(IDX_ENABLE, 8'h09);
    wr(IDX_ENABLE, 8'h01);
    rd_reg(IDX_STATUS);
    check_bit("loss cleared", 1'b0, rd[4]);
    wr(IDX_ENABLE, 8'h03);
    check_bit("cal busy", 1'b1, cal_busy_out);
    rd_reg(IDX_STATUS);
    check_bit("status cal", 1'b1, rd[2]);
    wr(IDX_ENABLE, 8'h01);
    for (i = 0; i < 300 && cal_busy_out !== 1'b0; i++) @(posedge clk_in);
    check_bit("cal done", 1'b0, cal_busy_out);
    wr(IDX_ENABLE, 8'h00);
    check_bit("power", 1'b0, pll_power_out);
    pll_lock_in <= 1'b0;
    reg_above_in <= 1'b0;
    wr(IDX_ENABLE, 8'h21);
    repeat (200) @(posedge clk_in);
    rd_chk("status no regulator", IDX_STATUS, 8'h00);
    reg_above_in <= 1'b1;
    for (i = 0; i < 600 && locked_out !== 1'b1; i++) @(posedge clk_in);
    check_bit("lock ignored", 1'b1, locked_out);
    complete_run();
  end
endmodule // tb_serializer_pll_control_regs
